// ---- emc_cycle_timer.sv ----
// external memory bus cycle sequencer with ahb-lite register slave
// assumes one ahb-lite master, single word transfers, async memory outside
//
// Local design decisions: the address map and the AHB-Lite slave port.
`timescale 1ns/10ps
`include "emc_regs.svh"
module emc_cycle_timer (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    output emc_pkg::emc_pins_type pins,
    input wire logic [`EMC_DATA_W-1:0] ext_rdata
);
    // register file and bus slave state
    logic pend_r, pend_nxt;
    logic [7:0] waddr_r, waddr_nxt;
    logic [31:0] hrdata_r, hrdata_nxt;
    logic [2:0] cd_reg_r, cd_reg_nxt;
    logic [14:0] param_r [`EMC_REGIONS], param_nxt [`EMC_REGIONS];
    logic [`EMC_ADDR_W-1:0] addr_reg_r, addr_reg_nxt;
    logic [`EMC_DATA_W-1:0] wdata_reg_r, wdata_reg_nxt;
    logic done_r, done_nxt;
    logic start_go;
    logic [31:0] ctrl_wd;

    // sequencer state
    emc_pkg::emc_state_type state_r, state_nxt;
    logic [9:0] cnt_r, cnt_nxt;
    logic [1:0] rgn_r, rgn_nxt;
    logic wr_r, wr_nxt;
    logic [2:0] cd_r, cd_nxt;
    logic [14:0] cfg_r, cfg_nxt;
    logic [1:0] ben_r, ben_nxt;
    logic [`EMC_DATA_W-1:0] rdata_r, rdata_nxt;
    logic seq_end;
    emc_pkg::emc_pins_type pins_r, pins_nxt;

    // phase lengths in half bus clocks for the latched region
    logic [5:0] h_ale, h_hold, h_gap, h_strb, h_rel;
    logic [14:0] cfg_use;

    assign ctrl_wd = hwdata;

    always_comb begin
        pend_nxt = 1'b0;
        waddr_nxt = waddr_r;
        hrdata_nxt = hrdata_r;
        cd_reg_nxt = cd_reg_r;
        param_nxt = param_r;
        addr_reg_nxt = addr_reg_r;
        wdata_reg_nxt = wdata_reg_r;
        done_nxt = done_r;
        start_go = 1'b0;
        if (hsel && htrans[1] && hready) begin
            pend_nxt = hwrite;
            waddr_nxt = haddr[7:0];
            hrdata_nxt = 32'h0000_0000;
            if (hwrite) begin
                hrdata_nxt = 32'h0000_0000;
            end else if (haddr[7:0] == `EMC_OFF_PWR) begin
                hrdata_nxt = {29'h0000_0000, cd_reg_r};
            end else if (haddr[7:0] >= `EMC_OFF_REG0 &&
                         haddr[7:0] <= `EMC_OFF_REG3) begin
                hrdata_nxt = {17'h0_0000,
                              param_r[2'(haddr[7:2] - 6'h01)]};
            end else if (haddr[7:0] == `EMC_OFF_ADDR) begin
                hrdata_nxt = {13'h0000, addr_reg_r};
            end else if (haddr[7:0] == `EMC_OFF_WDATA) begin
                hrdata_nxt = {16'h0000, wdata_reg_r};
            end else if (haddr[7:0] == `EMC_OFF_STAT) begin
                hrdata_nxt = {30'h0000_0000, done_r,
                              state_r != emc_pkg::ST_IDLE};
            end else if (haddr[7:0] == `EMC_OFF_RDATA) begin
                hrdata_nxt = {16'h0000, rdata_r};
            end
        end
        if (seq_end) begin
            done_nxt = 1'b1;
        end
        if (pend_r) begin
            if (waddr_r == `EMC_OFF_PWR) begin
                cd_reg_nxt = hwdata[`EMC_CD_MSB:0];
            end else if (waddr_r >= `EMC_OFF_REG0 &&
                         waddr_r <= `EMC_OFF_REG3) begin
                param_nxt[2'(waddr_r[7:2] - 6'h01)] = hwdata[14:0];
            end else if (waddr_r == `EMC_OFF_ADDR) begin
                addr_reg_nxt = hwdata[`EMC_ADDR_W-1:0];
            end else if (waddr_r == `EMC_OFF_WDATA) begin
                wdata_reg_nxt = hwdata[`EMC_DATA_W-1:0];
            end else if (waddr_r == `EMC_OFF_CTRL) begin
                // a start while busy is dropped, not queued
                if (ctrl_wd[`EMC_CTRL_START] &&
                    state_r == emc_pkg::ST_IDLE) begin
                    start_go = 1'b1;
                    done_nxt = 1'b0;
                end
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pend_r <= 1'b0;
            waddr_r <= 8'h00;
            hrdata_r <= 32'h0000_0000;
            cd_reg_r <= `EMC_PWR_RST;
            for (int i = 0; i < `EMC_REGIONS; i++) begin
                param_r[i] <= `EMC_PARAM_RST;
            end
            addr_reg_r <= '0;
            wdata_reg_r <= '0;
            done_r <= 1'b0;
        end else begin
            pend_r <= pend_nxt;
            waddr_r <= waddr_nxt;
            hrdata_r <= hrdata_nxt;
            cd_reg_r <= cd_reg_nxt;
            param_r <= param_nxt;
            addr_reg_r <= addr_reg_nxt;
            wdata_reg_r <= wdata_reg_nxt;
            done_r <= done_nxt;
        end
    end

    assign hrdata = hrdata_r;
    assign hreadyout = 1'b1 == hresetn ? 1'b1 : 1'b1;
    assign hresp = 1'b0 & hsize[0];

    // timing set of the region being started or running
    assign cfg_use = (state_r == emc_pkg::ST_IDLE) ?
                     param_r[ctrl_wd[`EMC_CTRL_RGN_LSB+:2]] : cfg_r;
    assign h_ale = 6'({cfg_use[`EMC_AE_MSB:`EMC_AE_LSB], 1'b0}) + 6'h02;
    assign h_hold = cfg_use[`EMC_AHOLD_BIT] ? 6'h01 : 6'h03;
    assign h_gap = (wr_r ? !cfg_r[`EMC_WHOLD_BIT]
                         : !cfg_r[`EMC_RHOLD_BIT]) ? 6'h02 : 6'h00;
    assign h_strb = wr_r ?
        6'({cfg_r[`EMC_WW_MSB:`EMC_WW_LSB], 1'b0}) + 6'h02 :
        6'({cfg_r[`EMC_RW_MSB:`EMC_RW_LSB], 1'b0}) + 6'h02;
    assign h_rel = (wr_r && !cfg_r[`EMC_WHOLD_BIT]) ? 6'h04 : 6'h02;

    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        rgn_nxt = rgn_r;
        wr_nxt = wr_r;
        cd_nxt = cd_r;
        cfg_nxt = cfg_r;
        ben_nxt = ben_r;
        rdata_nxt = rdata_r;
        seq_end = 1'b0;
        if (state_r == emc_pkg::ST_IDLE) begin
            if (start_go) begin
                rgn_nxt = ctrl_wd[`EMC_CTRL_RGN_LSB+:2];
                wr_nxt = ctrl_wd[`EMC_CTRL_WRITE];
                ben_nxt = ctrl_wd[`EMC_CTRL_BEN_LSB+:2];
                cfg_nxt = cfg_use;
                cd_nxt = cd_reg_r;
                state_nxt = emc_pkg::ST_PRE;
                cnt_nxt = emc_pkg::cycles(6'h01, cd_reg_r) - 10'h001;
            end
        end else if (cnt_r != 10'h000) begin
            cnt_nxt = cnt_r - 10'h001;
        end else begin
            case (state_r)
                emc_pkg::ST_PRE: begin
                    state_nxt = emc_pkg::ST_ALE;
                    cnt_nxt = emc_pkg::cycles(h_ale, cd_r) - 10'h001;
                end
                emc_pkg::ST_ALE: begin
                    state_nxt = emc_pkg::ST_AHOLD;
                    cnt_nxt = emc_pkg::cycles(h_hold, cd_r) - 10'h001;
                end
                emc_pkg::ST_AHOLD: begin
                    if (h_gap != 6'h00) begin
                        state_nxt = emc_pkg::ST_GAP;
                        cnt_nxt = emc_pkg::cycles(h_gap, cd_r) - 10'h001;
                    end else begin
                        state_nxt = emc_pkg::ST_STROBE;
                        cnt_nxt = emc_pkg::cycles(h_strb, cd_r) - 10'h001;
                    end
                end
                emc_pkg::ST_GAP: begin
                    state_nxt = emc_pkg::ST_STROBE;
                    cnt_nxt = emc_pkg::cycles(h_strb, cd_r) - 10'h001;
                end
                emc_pkg::ST_STROBE: begin
                    // sampled as the strobe rises; memory still drives it
                    if (!wr_r) begin
                        rdata_nxt = ext_rdata;
                    end
                    state_nxt = emc_pkg::ST_REL;
                    cnt_nxt = emc_pkg::cycles(h_rel, cd_r) - 10'h001;
                end
                emc_pkg::ST_REL: begin
                    state_nxt = emc_pkg::ST_IDLE;
                    seq_end = 1'b1;
                end
                default: begin
                    state_nxt = emc_pkg::ST_IDLE;
                end
            endcase
        end
        pins_nxt = '0;
        pins_nxt.memory_select_n = (state_nxt == emc_pkg::ST_IDLE) ?
            4'hF : ~(4'h1 << rgn_nxt);
        pins_nxt.address_latch_enable = (state_nxt == emc_pkg::ST_ALE);
        pins_nxt.wr_n = !(state_nxt == emc_pkg::ST_STROBE && wr_nxt);
        pins_nxt.rd_n = !(state_nxt == emc_pkg::ST_STROBE && !wr_nxt);
        pins_nxt.byte_lane_enable_n = (state_nxt == emc_pkg::ST_IDLE ||
            state_nxt == emc_pkg::ST_PRE || state_nxt == emc_pkg::ST_ALE) ?
            2'h3 : ~ben_nxt;
        pins_nxt.addr = addr_reg_r;
        pins_nxt.addr_oe = (state_nxt == emc_pkg::ST_PRE ||
            state_nxt == emc_pkg::ST_ALE ||
            state_nxt == emc_pkg::ST_AHOLD);
        pins_nxt.dout = wdata_reg_r;
        pins_nxt.dout_oe = wr_nxt && (state_nxt == emc_pkg::ST_GAP ||
            state_nxt == emc_pkg::ST_STROBE || state_nxt == emc_pkg::ST_REL);
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_r <= emc_pkg::ST_IDLE;
            cnt_r <= 10'h000;
            rgn_r <= 2'h0;
            wr_r <= 1'b0;
            cd_r <= `EMC_PWR_RST;
            cfg_r <= `EMC_PARAM_RST;
            ben_r <= 2'h0;
            rdata_r <= '0;
            pins_r <= '{memory_select_n: 4'hF, address_latch_enable: 1'b0,
                        wr_n: 1'b1, rd_n: 1'b1, byte_lane_enable_n: 2'h3,
                        addr: '0, addr_oe: 1'b0, dout: '0, dout_oe: 1'b0};
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            rgn_r <= rgn_nxt;
            wr_r <= wr_nxt;
            cd_r <= cd_nxt;
            cfg_r <= cfg_nxt;
            ben_r <= ben_nxt;
            rdata_r <= rdata_nxt;
            pins_r <= pins_nxt;
        end
    end

    assign pins = pins_r;

    // cycles spent at the current pin level, checker only
    logic [9:0] st_cyc_r;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_cyc_r <= 10'h000;
        end else begin
            st_cyc_r <= (state_nxt != state_r) ? 10'h001 : st_cyc_r + 10'h001;
        end
    end

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    a_pre_half: assert property ($rose(pins.address_latch_enable) |->
        $past(st_cyc_r) == emc_pkg::cycles(6'h01, cd_r))
        else $error("select to ale spacing wrong");
    a_ale_width: assert property ($fell(pins.address_latch_enable) |->
        $past(st_cyc_r) == emc_pkg::cycles(h_ale, cd_r))
        else $error("ale width wrong");
    a_addr_hold: assert property ($fell(pins.addr_oe) &&
        !pins.memory_select_n[rgn_r] |->
        $past(st_cyc_r) == emc_pkg::cycles(h_hold, cd_r))
        else $error("address hold wrong");
    // gap length checked too, not only that the gap state was passed
    a_wr_gap: assert property ($fell(pins.wr_n) |->
        (cfg_r[`EMC_WHOLD_BIT] ? $past(state_r) == emc_pkg::ST_AHOLD :
        ($past(state_r) == emc_pkg::ST_GAP &&
        $past(st_cyc_r) == emc_pkg::cycles(6'h02, cd_r))))
        else $error("write strobe delay wrong");
    a_wr_width: assert property ($rose(pins.wr_n) |->
        $past(st_cyc_r) == emc_pkg::cycles(h_strb, cd_r))
        else $error("write strobe width wrong");
    a_rd_gap: assert property ($fell(pins.rd_n) |->
        (cfg_r[`EMC_RHOLD_BIT] ? $past(state_r) == emc_pkg::ST_AHOLD :
        ($past(state_r) == emc_pkg::ST_GAP &&
        $past(st_cyc_r) == emc_pkg::cycles(6'h02, cd_r))))
        else $error("read strobe delay wrong");
    a_rd_width: assert property ($rose(pins.rd_n) |->
        $past(st_cyc_r) == emc_pkg::cycles(h_strb, cd_r))
        else $error("read strobe width wrong");
    a_ms_release: assert property ($rose(pins.memory_select_n[rgn_r]) |->
        $past(st_cyc_r) == emc_pkg::cycles(h_rel, cd_r) && $past(pins.wr_n)
        && $past(pins.rd_n))
        else $error("select release wrong");
    a_region_sel: assert property (pins.memory_select_n != 4'hF |->
        pins.memory_select_n == ~(4'h1 << rgn_r))
        else $error("wrong region selected");

    c_write: cover property ($rose(pins.wr_n));
    c_read: cover property ($rose(pins.rd_n));
    c_div: cover property ($rose(pins.address_latch_enable) && cd_r != 3'h0);
endmodule

// ---- emc_regs.svh ----
// register offsets, field positions and reset values of the cycle timer
// assumes a 32-bit ahb-lite slave with word-aligned registers
`ifndef EMC_REGS_SVH
`define EMC_REGS_SVH
`define EMC_OFF_PWR 8'h00
`define EMC_OFF_REG0 8'h04
`define EMC_OFF_REG1 8'h08
`define EMC_OFF_REG2 8'h0C
`define EMC_OFF_REG3 8'h10
`define EMC_OFF_ADDR 8'h14
`define EMC_OFF_WDATA 8'h18
`define EMC_OFF_CTRL 8'h1C
`define EMC_OFF_STAT 8'h20
`define EMC_OFF_RDATA 8'h24
`define EMC_CD_MSB 2
`define EMC_AE_MSB 14
`define EMC_AE_LSB 12
`define EMC_AHOLD_BIT 10
`define EMC_RHOLD_BIT 9
`define EMC_WHOLD_BIT 8
`define EMC_WW_MSB 7
`define EMC_WW_LSB 4
`define EMC_RW_MSB 3
`define EMC_RW_LSB 0
`define EMC_CTRL_START 0
`define EMC_CTRL_WRITE 1
`define EMC_CTRL_RGN_LSB 4
`define EMC_CTRL_BEN_LSB 8
`define EMC_STAT_BUSY 0
`define EMC_STAT_DONE 1
`define EMC_PWR_RST 3'h0
`define EMC_PARAM_RST 15'h0000
`define EMC_ADDR_W 19
`define EMC_DATA_W 16
`define EMC_REGIONS 4
`endif

// ---- emc_pkg.sv ----
// types shared by the external memory cycle timer
// assumes emc_regs.svh for widths
`include "emc_regs.svh"
package emc_pkg;
    typedef enum logic [2:0] {
        ST_IDLE, ST_PRE, ST_ALE, ST_AHOLD, ST_GAP, ST_STROBE, ST_REL
    } emc_state_type;

    typedef struct packed {
        logic [`EMC_REGIONS-1:0] memory_select_n;
        logic address_latch_enable;
        logic wr_n;
        logic rd_n;
        logic [1:0] byte_lane_enable_n;
        logic [`EMC_ADDR_W-1:0] addr;
        logic addr_oe;
        logic [`EMC_DATA_W-1:0] dout;
        logic dout_oe;
    } emc_pins_type;

    // half bus clocks to hclk cycles, bus clock = (cd + 1) hclk
    function automatic logic [9:0] cycles(input logic [5:0] halves,
                                          input logic [2:0] cd);
        logic [9:0] prod;
        prod = 10'(halves * (4'(cd) + 4'h1)) + 10'h001;
        return {1'b0, prod[9:1]};
    endfunction
endpackage

// ---- emc_mem_model.sv ----
// async memory model on the pin side of the cycle timer
// assumes one 16-bit device, 16 words deep, decoded on addr[3:0]
`timescale 1ns/10ps
module emc_mem_model (
    input wire logic hclk,
    input emc_pkg::emc_pins_type pins,
    input wire logic [3:0] hold_n,
    output logic [15:0] ext_rdata
);
    logic [15:0] mem [16];
    logic [15:0] last;
    logic [3:0] cnt;
    logic wr_q;
    initial begin
        for (int i = 0; i < 16; i++) begin
            mem[i] = 16'h0000;
        end
        last = 16'h0000;
        cnt = 4'h0;
        wr_q = 1'b1;
    end
    always @(posedge hclk) begin
        wr_q <= pins.wr_n;
        if (!wr_q && pins.wr_n) begin
            mem[pins.addr[3:0]] <= pins.dout;
        end
        if (!pins.rd_n) begin
            last <= mem[pins.addr[3:0]];
            cnt <= hold_n;
        end else if (cnt != 4'h0) begin
            cnt <= cnt - 4'h1;
        end
    end
    // released bus holds the last word for hold_n cycles, then shows the inverse so a late sample cannot match
    assign ext_rdata = !pins.rd_n ? mem[pins.addr[3:0]] :
        (cnt != 4'h0 ? last : ~last);
endmodule

// ---- tb.sv ----
// testbench: ahb-lite register access and pin-phase timing checks
// assumes hreadyout feeds hready and emc_mem_model on the pins
`timescale 1ns/10ps
`include "emc_regs.svh"
module tb;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, rv;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [15:0] ext_rdata, mem_exp;
    logic [3:0] hold_n, sel_seen;
    logic p_ale, p_stb, p_sel, p_oe;
    emc_pkg::emc_pins_type pins;
    int n_mismatch, n_checks, cyc, tcnt;
    int ale_r, ale_f, stb_f, stb_r, sel_f, sel_r, oe_f;
    int cd_t [4] = '{0, 1, 2, 3};
    int wr_t [4] = '{1, 0, 0, 1};
    logic [14:0] pr_t [4] = '{15'h0000, 15'h2735, 15'h1412, 15'h0120};
    logic [15:0] wd_t [4] = '{16'hA5C3, 16'h0000, 16'h0000, 16'h5AF0};
    emc_cycle_timer uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .pins(pins),
        .ext_rdata(ext_rdata));
    emc_mem_model mdl (.hclk(hclk), .pins(pins), .hold_n(hold_n),
        .ext_rdata(ext_rdata));
    initial begin
        hclk = 1'b0;
        forever #25 hclk = ~hclk;
    end
    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] exp,
                       input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic ahb(input logic w, input logic [31:0] a,
                       input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rv = hrdata;
    endtask
    function automatic int hc(int n, int cd);
        return (n * (cd + 1) + 1) / 2;
    endfunction
    task automatic op(input int k);
        logic [14:0] p;
        int cd;
        int hb;
        p = pr_t[k];
        cd = cd_t[k];
        hb = wr_t[k] ? p[8] : p[9];
        hold_n <= p[9] ? 4'h0 : 4'(cd + 1);
        ahb(1'b1, 32'(`EMC_OFF_PWR), 32'(cd));
        ahb(1'b1, 32'(`EMC_OFF_ADDR), 32'h00012345);
        ahb(1'b1, 32'(`EMC_OFF_WDATA), 32'(wd_t[k]));
        ahb(1'b1, 32'(`EMC_OFF_CTRL), 32'h300 | 32'(k << 4) |
            32'(wr_t[k] << 1) | 32'h1);
        for (int i = 0; i < 60; i++) begin
            ahb(1'b0, 32'(`EMC_OFF_STAT), 32'h0);
            if (rv[1] === 1'b1) break;
        end
        chk("done", 32'h1, 32'(rv[1]));
        chk("select", 32'(1 << k), 32'(sel_seen));
        chk("ale_delay", hc(1, cd), ale_r - sel_f);
        chk("ale_len", hc(2 * (p[14:12] + 1), cd), ale_f - ale_r);
        chk("addr_hold", hc(p[10] ? 1 : 3, cd), oe_f - ale_f);
        chk("stb_delay", hc(p[10] ? 1 : 3, cd) + (hb ? 0 : hc(2, cd)),
            stb_f - ale_f);
        if (wr_t[k]) begin
            chk("wr_len", hc(2 * (p[7:4] + 1), cd), stb_r - stb_f);
            chk("wr_rel", hc(p[8] ? 2 : 4, cd), sel_r - stb_r);
            mem_exp = wd_t[k];
        end else begin
            chk("rd_len", hc(2 * (p[3:0] + 1), cd), stb_r - stb_f);
            chk("rd_rel", hc(2, cd), sel_r - stb_r);
            ahb(1'b0, 32'(`EMC_OFF_RDATA), 32'h0);
            chk("rdata", 32'(mem_exp), rv);
        end
    endtask
    always @(negedge hclk) begin
        cyc = cyc + 1;
        if (pins.address_latch_enable && !p_ale) ale_r = cyc;
        if (!pins.address_latch_enable && p_ale) ale_f = cyc;
        if (!(pins.wr_n & pins.rd_n) && p_stb) stb_f = cyc;
        if ((pins.wr_n & pins.rd_n) && !p_stb) stb_r = cyc;
        if (!(&pins.memory_select_n) && p_sel) begin
            sel_f = cyc;
            sel_seen = ~pins.memory_select_n;
        end
        if ((&pins.memory_select_n) && !p_sel) sel_r = cyc;
        if (!pins.addr_oe && p_oe) oe_f = cyc;
        p_oe = pins.addr_oe;
        p_ale = pins.address_latch_enable;
        p_stb = pins.wr_n & pins.rd_n;
        p_sel = &pins.memory_select_n;
    end
    always @(posedge hclk) begin
        tcnt = tcnt + 1;
        if (tcnt == 20000) begin
            n_mismatch++;
            finish_test();
        end
    end
    initial begin
        {hresetn, hsel, hwrite, haddr, hwdata, htrans} = '0;
        hsize = 3'h2;
        hold_n = 4'h0;
        mem_exp = 16'h0000;
        {p_ale, p_stb, p_sel, p_oe} = 4'b0110;
        {n_mismatch, n_checks, cyc, tcnt} = '0;
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        chk("sel_rst", 32'hF, 32'(pins.memory_select_n));
        ahb(1'b0, 32'(`EMC_OFF_PWR), 32'h0);
        chk("pwr_rst", 32'h0, rv);
        ahb(1'b0, 32'h00000028, 32'h0);
        chk("unmapped", 32'h0, rv);
        for (int k = 0; k < 4; k++) begin
            ahb(1'b1, 32'(`EMC_OFF_REG0) + 32'(4 * k), 32'(pr_t[k]));
        end
        ahb(1'b0, 32'(`EMC_OFF_REG1), 32'h0);
        chk("reg1", 32'h2735, rv);
        for (int k = 0; k < 4; k++) begin
            op(k);
        end
        // read back what the last write cycle left in the memory
        op(1);
        finish_test();
    end
endmodule
